// file: hdl/tfp_pkg.sv
// Constants for the timer flag, period compare and fast clock control block
package tfp_pkg;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [5:0] IDX_PLL_CTRL  = 6'h27;
  localparam logic [5:0] IDX_IRQ_FLAG  = 6'h38;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h39;
  localparam logic [5:0] IDX_PERIOD    = 6'h3a;
  localparam logic [5:0] IDX_TMR_CTRL  = 6'h3b;
  localparam logic [5:0] IDX_COUNTER   = 6'h3c;
  localparam logic [5:0] IDX_CMP_A     = 6'h3d;
  localparam logic [5:0] IDX_CMP_B     = 6'h3e;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CMP_A      = 6;
  localparam int BIT_CMP_B      = 5;
  localparam int BIT_OVF        = 2;
  localparam int BIT_LOW_SPEED  = 7;
  localparam int BIT_FAST_SEL   = 2;
  localparam int BIT_PLL_EN     = 1;
  localparam int BIT_PLL_LOCKED = 0;
  localparam int BIT_RUN        = 0;
  localparam int BIT_PWM_A      = 1;
  localparam int BIT_PWM_B      = 2;
  localparam int BIT_CTC        = 3;

  // Writable and readable bits of the flag and mask registers and of the timer control register
  localparam logic [7:0] FLAG_BITS  = 8'h64;
  localparam logic [7:0] CTRL_BITS  = 8'h0f;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int LOCK_TIME_US  = 100;
  localparam int LOCK_CYC      = (LOCK_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_W        = 12;

endpackage

// file: hdl/tfp_top.sv
// Timer flags, period compare, counter and fast clock control behind AXI4-Lite
`timescale 1ns/100ps

// Operation
// [R1] Compare C match only when counting into value
// [R2] Software write never causes a compare match
// [R3] Clear-on-compare C resets counter on match
// [R4] Period compare is 8-bit read write
// [R5] Compare A request needs global, enable, flag
// [R6] Compare B request needs global, enable, flag
// [R7] Overflow request needs global, enable, flag
// [R8] Reserved mask, flag, PLL bits read zero
// [R9] Compare A flag set on match, cleared
// [R10] Compare B flag set on match, cleared
// [R11] Normal mode overflow sets overflow flag
// [R12] PWM mode compare C sets overflow flag
// [R13] Fast clock 64 MHz, low speed halves
// [R14] Software stops counter before low speed change
// [R15] Clock source bit picks fast or system
// [R16] Clock source set only while PLL enabled
// [R17] PLL enable starts PLL, reads one forced
// [R18] Lock bit set after 100 us
// [R19] Software enables, polls lock, then selects
// [R20] Zero writes and read-only writes ignored
module tfp_top
  import tfp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // CPU side
  input  wire logic              global_irq_en,
  input  wire logic              ack_cmp_a,
  input  wire logic              ack_cmp_b,
  input  wire logic              ack_ovf,
  output logic                   irq_cmp_a,
  output logic                   irq_cmp_b,
  output logic                   irq_ovf,
  // Fast clock side
  input  wire logic              fast_tick,
  input  wire logic              pll_is_sysclk,
  output logic                   pll_run,
  output logic                   fast_clk_active
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
    idx_hit = (a[7:2] == idx);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = idx_hit(a, IDX_PLL_CTRL) || idx_hit(a, IDX_IRQ_FLAG) ||
             idx_hit(a, IDX_IRQ_MASK) || idx_hit(a, IDX_PERIOD) ||
             idx_hit(a, IDX_TMR_CTRL) || idx_hit(a, IDX_COUNTER) ||
             idx_hit(a, IDX_CMP_A) || idx_hit(a, IDX_CMP_B);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic              aw_have_q, w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic [7:0]        flag_q, flag_d, mask_q, period_q, ctrl_q, cnt_q, cmp_a_q, cmp_b_q;
  logic [7:0]        clr_pend_q;
  logic              low_speed_q, fast_sel_q, pll_en_q, locked_q, half_q;
  logic [LOCK_W-1:0] lock_cnt_q;
  logic [7:0]        cnt_d;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  wire aw_hs  = s_axi_awvalid && s_axi_awready;
  wire w_hs   = s_axi_wvalid && s_axi_wready;
  wire do_wr  = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_ok  = do_wr && wlane_q;
  wire wr_flag   = wr_ok && idx_hit(waddr_q, IDX_IRQ_FLAG);
  wire wr_mask   = wr_ok && idx_hit(waddr_q, IDX_IRQ_MASK);
  wire wr_period = wr_ok && idx_hit(waddr_q, IDX_PERIOD);
  wire wr_ctrl   = wr_ok && idx_hit(waddr_q, IDX_TMR_CTRL);
  wire wr_cnt    = wr_ok && idx_hit(waddr_q, IDX_COUNTER);
  wire wr_cmp_a  = wr_ok && idx_hit(waddr_q, IDX_CMP_A);
  wire wr_cmp_b  = wr_ok && idx_hit(waddr_q, IDX_CMP_B);
  wire wr_pll    = wr_ok && idx_hit(waddr_q, IDX_PLL_CTRL);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      waddr_q       <= '0;
      wbyte_q       <= RST_BYTE;
      wlane_q       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_have_q     <= 1'b1;
        waddr_q       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_have_q     <= 1'b1;
        wbyte_q      <= s_axi_wdata[7:0];
        wlane_q      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read value of each register, reserved bits zero
  wire [7:0] rd_pll = {low_speed_q, 4'h0, fast_sel_q, pll_en_q || pll_is_sysclk, locked_q}; // [R8] [R17]
  wire [7:0] rd_val =
      idx_hit(s_axi_araddr, IDX_PLL_CTRL) ? rd_pll :
      idx_hit(s_axi_araddr, IDX_IRQ_FLAG) ? (flag_q & FLAG_BITS) : // [R8]
      idx_hit(s_axi_araddr, IDX_IRQ_MASK) ? (mask_q & FLAG_BITS) : // [R8]
      idx_hit(s_axi_araddr, IDX_PERIOD)   ? period_q : // [R4]
      idx_hit(s_axi_araddr, IDX_TMR_CTRL) ? ctrl_q :
      idx_hit(s_axi_araddr, IDX_COUNTER)  ? cnt_q :
      idx_hit(s_axi_araddr, IDX_CMP_A)    ? cmp_a_q :
      idx_hit(s_axi_araddr, IDX_CMP_B)    ? cmp_b_q : RST_BYTE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_val};
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // PLL control and lock
  // ****************************************
  wire pll_on = pll_en_q || pll_is_sysclk; // [R17]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_speed_q <= 1'b0;
      fast_sel_q  <= 1'b0;
      pll_en_q    <= 1'b0;
      locked_q    <= 1'b0;
      lock_cnt_q  <= '0;
      half_q      <= 1'b0;
    end else begin
      if (wr_pll) begin
        low_speed_q <= wbyte_q[BIT_LOW_SPEED]; // [R13]
        pll_en_q    <= wbyte_q[BIT_PLL_EN];
        // Clock source may only rise while the PLL was already on
        fast_sel_q  <= wbyte_q[BIT_FAST_SEL] && (pll_on || fast_sel_q); // [R16]
      end
      if (!pll_on) begin
        lock_cnt_q <= '0;
        locked_q   <= 1'b0;
      end else if (lock_cnt_q != LOCK_W'(LOCK_CYC)) begin
        lock_cnt_q <= lock_cnt_q + 1'b1;
      end else begin
        locked_q <= 1'b1; // [R18]
      end
      if (fast_tick) begin
        half_q <= !half_q;
      end
    end
  end

  // Low speed passes every second fast tick
  wire fast_en = fast_tick && (!low_speed_q || half_q); // [R13]
  wire tick    = ctrl_q[BIT_RUN] && (fast_sel_q ? fast_en : 1'b1); // [R15]

  a_src_needs_pll: assert property (@(posedge clk) disable iff (rst) // [R16]
    $rose(fast_sel_q) |-> $past(pll_en_q) || $past(pll_is_sysclk))
    else $error("clock source set without PLL enabled");

  a_lock_time: assert property (@(posedge clk) disable iff (rst) // [R18]
    $rose(locked_q) |-> $past(lock_cnt_q) == LOCK_W'(LOCK_CYC) && $past(pll_on))
    else $error("PLL lock reported at wrong count");

  // ****************************************
  // Counter and compare
  // ****************************************
  wire pwm      = ctrl_q[BIT_PWM_A] || ctrl_q[BIT_PWM_B];
  wire wrap_c   = ctrl_q[BIT_CTC] || pwm;
  wire at_top   = (cnt_q == period_q);
  wire [7:0] nx = cnt_q + 8'h01;
  wire adv      = tick && !wr_cnt; // [R2]
  wire match_c  = adv && !(wrap_c && at_top) && (nx == period_q); // [R1]
  wire match_a  = adv && (cnt_d == cmp_a_q);
  wire match_b  = adv && (cnt_d == cmp_b_q);
  wire ovf_ev   = pwm ? match_c : (adv && cnt_q == 8'hff && !(wrap_c && at_top)); // [R11] [R12]

  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt) begin
      cnt_d = wbyte_q;
    end else if (tick) begin
      cnt_d = (wrap_c && at_top) ? 8'h00 : nx; // [R3]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q    <= RST_BYTE;
      period_q <= RST_PERIOD;
      ctrl_q   <= RST_BYTE;
      cmp_a_q  <= RST_BYTE;
      cmp_b_q  <= RST_BYTE;
      mask_q   <= RST_BYTE;
    end else begin
      cnt_q <= cnt_d;
      if (wr_period) period_q <= wbyte_q; // [R4]
      if (wr_ctrl)   ctrl_q   <= wbyte_q & CTRL_BITS;
      if (wr_cmp_a)  cmp_a_q  <= wbyte_q;
      if (wr_cmp_b)  cmp_b_q  <= wbyte_q;
      if (wr_mask)   mask_q   <= wbyte_q & FLAG_BITS; // [R8]
    end
  end

  a_match_on_count: assert property (@(posedge clk) disable iff (rst) // [R1]
    match_c |=> cnt_q == period_q && $past(cnt_q) != period_q)
    else $error("compare C match without counting into value");

  a_write_no_match: assert property (@(posedge clk) disable iff (rst) // [R2]
    wr_cnt |-> !match_c && !match_a && !match_b)
    else $error("software write produced a match");

  a_ctc_clear: assert property (@(posedge clk) disable iff (rst) // [R3]
    ctrl_q[BIT_CTC] && tick && !wr_cnt && at_top |=> cnt_q == 8'h00)
    else $error("clear on compare C did not zero counter");

  // ****************************************
  // Flags and interrupt requests
  // ****************************************
  wire [7:0] set_v = {1'b0, match_a, match_b, 2'b00, ovf_ev, 2'b00};
  wire [7:0] ack_v = {1'b0, ack_cmp_a, ack_cmp_b, 2'b00, ack_ovf, 2'b00};

  // Set wins over both clears
  assign flag_d = ((flag_q & ~(clr_pend_q | ack_v)) | set_v) & FLAG_BITS; // [R9] [R10] [R11]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q     <= RST_BYTE;
      clr_pend_q <= RST_BYTE;
      irq_cmp_a  <= 1'b0;
      irq_cmp_b  <= 1'b0;
      irq_ovf    <= 1'b0;
      pll_run    <= 1'b0;
      fast_clk_active <= 1'b0;
    end else begin
      flag_q     <= flag_d;
      // Write-one clears act one cycle later, zeros change nothing
      clr_pend_q <= wr_flag ? (wbyte_q & FLAG_BITS) : RST_BYTE; // [R20]
      irq_cmp_a  <= global_irq_en && mask_q[BIT_CMP_A] && flag_q[BIT_CMP_A]; // [R5]
      irq_cmp_b  <= global_irq_en && mask_q[BIT_CMP_B] && flag_q[BIT_CMP_B]; // [R6]
      irq_ovf    <= global_irq_en && mask_q[BIT_OVF] && flag_q[BIT_OVF]; // [R7]
      pll_run    <= pll_on; // [R17]
      fast_clk_active <= fast_sel_q; // [R15]
    end
  end

  a_irq_a_gate: assert property (@(posedge clk) disable iff (rst) // [R5]
    irq_cmp_a == $past(global_irq_en && mask_q[BIT_CMP_A] && flag_q[BIT_CMP_A]))
    else $error("compare A request mismatch");

  a_irq_b_gate: assert property (@(posedge clk) disable iff (rst) // [R6]
    irq_cmp_b |-> $past(global_irq_en) && $past(mask_q[BIT_CMP_B]) && $past(flag_q[BIT_CMP_B]))
    else $error("compare B request without cause");

  a_irq_ovf_gate: assert property (@(posedge clk) disable iff (rst) // [R7]
    global_irq_en && mask_q[BIT_OVF] && flag_q[BIT_OVF] |=> irq_ovf)
    else $error("overflow request missing");

  a_flag_a_set: assert property (@(posedge clk) disable iff (rst) // [R9]
    match_a |=> flag_q[BIT_CMP_A])
    else $error("compare A flag not set");

  a_flag_a_wclr: assert property (@(posedge clk) disable iff (rst) // [R9]
    wr_flag && wbyte_q[BIT_CMP_A] && !match_a ##1 !match_a |=> !flag_q[BIT_CMP_A])
    else $error("compare A flag not cleared by write");

  a_flag_b_ack: assert property (@(posedge clk) disable iff (rst) // [R10]
    ack_cmp_b && !match_b |=> !flag_q[BIT_CMP_B])
    else $error("compare B flag not cleared by vector");

  a_ovf_pwm: assert property (@(posedge clk) disable iff (rst) // [R12]
    pwm && match_c |=> flag_q[BIT_OVF])
    else $error("PWM compare C did not set overflow flag");

  a_flag_zero_keep: assert property (@(posedge clk) disable iff (rst) // [R20]
    wr_flag && !wbyte_q[BIT_OVF] && flag_q[BIT_OVF] && !ack_ovf ##1 !ack_ovf |=> flag_q[BIT_OVF])
    else $error("zero write changed overflow flag");

  a_mask_rsvd: assert property (@(posedge clk) disable iff (rst) // [R8]
    mask_q[7] == 1'b0 && mask_q[0] == 1'b0 && flag_q[7] == 1'b0 && flag_q[0] == 1'b0)
    else $error("reserved bit stored");

endmodule // tfp_top

// file: verif/testbench.sv
// Self-checking bench for the timer flag, period compare and fast clock block
`timescale 1ns/100ps
module testbench;
  import tfp_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, gie, ack_a, ack_b, ack_o;
  logic        irq_a, irq_b, irq_o, ftick, pll_sys, pll_run, fast_act;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          error_cnt, n_compared, cyc_cnt, t0, n;

  tfp_top i_dut (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .global_irq_en(gie), .ack_cmp_a(ack_a), .ack_cmp_b(ack_b), .ack_ovf(ack_o),
    .irq_cmp_a(irq_a), .irq_cmp_b(irq_b), .irq_ovf(irq_o), .fast_tick(ftick),
    .pll_is_sysclk(pll_sys), .pll_run(pll_run), .fast_clk_active(fast_act)
  );

  // ****************************************
  // Clock and timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // Write one register; entered and left just after a rising edge
  task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] er);
    logic ta, tw, da, dw, b;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) begin
        da = 1'b1;
        awvalid <= 1'b0;
      end
      if (tw) begin
        dw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(negedge clk);
      b = bvalid;
      r = bresp;
      @(posedge clk);
    end while (!b);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] v, input logic [1:0] er);
    logic t, b;
    logic [1:0] r;
    t = 1'b0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    while (!t) begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do begin
      @(negedge clk);
      b = rvalid;
      r = rresp;
      v = rdata;
      @(posedge clk);
    end while (!b);
    rready <= 1'b0;
    chk({30'h0, r}, {30'h0, er}, "read response");
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp, input string msg);
    logic [31:0] v;
    rd(idx, v, RESP_OKAY);
    chk(v, {24'h000000, exp}, msg);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic ticks(input int k);
    repeat (k) begin
      ftick <= 1'b1;
      @(posedge clk);
      ftick <= 1'b0;
      @(posedge clk);
    end
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, gie, ack_a, ack_b, ack_o} = '0;
    {ftick, pll_sys} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    error_cnt = 0;
    n_compared = 0;
    cyc_cnt = 0;
    rst = 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    rchk(IDX_IRQ_FLAG, 8'h00, "flag reset");
    rchk(IDX_PERIOD, RST_PERIOD, "period reset");
    rchk(IDX_PLL_CTRL, 8'h00, "pll reset");
    wr(IDX_PERIOD, 8'ha5, RESP_OKAY);
    rchk(IDX_PERIOD, 8'ha5, "period rw");
    wr(IDX_IRQ_MASK, 8'hff, RESP_OKAY);
    rchk(IDX_IRQ_MASK, 8'h64, "mask reserved");
    wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
    wr(6'h00, 8'h55, RESP_SLVERR);
    rd(6'h00, d, RESP_SLVERR);
    chk(d, 32'h0, "unmapped read");
    // Equal values by software write never match
    wr(IDX_PERIOD, 8'h05, RESP_OKAY);
    wr(IDX_CMP_A, 8'h05, RESP_OKAY);
    wr(IDX_COUNTER, 8'h10, RESP_OKAY);
    wr(IDX_TMR_CTRL, 8'h01, RESP_OKAY);
    wr(IDX_COUNTER, 8'h05, RESP_OKAY);
    cyc(4);
    wr(IDX_TMR_CTRL, 8'h00, RESP_OKAY);
    rchk(IDX_IRQ_FLAG, 8'h00, "write no match");
    // Compare A interrupt and vector acknowledge
    wr(IDX_CMP_A, 8'h03, RESP_OKAY);
    wr(IDX_CMP_B, 8'h80, RESP_OKAY);
    wr(IDX_PERIOD, 8'hff, RESP_OKAY);
    wr(IDX_COUNTER, 8'h00, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h40, RESP_OKAY);
    gie <= 1'b1;
    wr(IDX_TMR_CTRL, 8'h01, RESP_OKAY);
    n = 0;
    while (irq_a !== 1'b1 && n < 20) begin
      @(negedge clk);
      @(posedge clk);
      n = n + 1;
    end
    chk({31'h0, irq_a}, 32'h1, "irq a raised");
    chk({31'h0, irq_b}, 32'h0, "irq b quiet");
    ack_a <= 1'b1;
    cyc(1);
    ack_a <= 1'b0;
    cyc(2);
    chk({31'h0, irq_a}, 32'h0, "irq a after ack");
    // Compare B flag, zero writes and write-one clear
    wr(IDX_TMR_CTRL, 8'h00, RESP_OKAY);
    wr(IDX_CMP_A, 8'h80, RESP_OKAY);
    wr(IDX_CMP_B, 8'h04, RESP_OKAY);
    wr(IDX_COUNTER, 8'h00, RESP_OKAY);
    wr(IDX_TMR_CTRL, 8'h01, RESP_OKAY);
    cyc(20);
    wr(IDX_TMR_CTRL, 8'h00, RESP_OKAY);
    rchk(IDX_IRQ_FLAG, 8'h20, "cmp b flag");
    wr(IDX_IRQ_MASK, 8'h20, RESP_OKAY);
    cyc(2);
    chk({31'h0, irq_b}, 32'h1, "irq b raised");
    wr(IDX_IRQ_FLAG, 8'h9b, RESP_OKAY);
    rchk(IDX_IRQ_FLAG, 8'h20, "zero write kept");
    wr(IDX_IRQ_FLAG, 8'h20, RESP_OKAY);
    rchk(IDX_IRQ_FLAG, 8'h00, "cmp b cleared");
    chk({31'h0, irq_b}, 32'h0, "irq b after clear");
    // Normal overflow, global gate and vector acknowledge
    wr(IDX_CMP_B, 8'h80, RESP_OKAY);
    wr(IDX_IRQ_MASK, 8'h04, RESP_OKAY);
    wr(IDX_COUNTER, 8'hfd, RESP_OKAY);
    wr(IDX_TMR_CTRL, 8'h01, RESP_OKAY);
    cyc(10);
    wr(IDX_TMR_CTRL, 8'h00, RESP_OKAY);
    rchk(IDX_IRQ_FLAG, 8'h04, "overflow flag");
    chk({31'h0, irq_o}, 32'h1, "irq ovf raised");
    gie <= 1'b0;
    cyc(2);
    chk({31'h0, irq_o}, 32'h0, "irq ovf gated");
    ack_o <= 1'b1;
    cyc(1);
    ack_o <= 1'b0;
    cyc(1);
    rchk(IDX_IRQ_FLAG, 8'h00, "ovf ack clear");
    // Clear on compare C: counter wraps at period, no overflow
    wr(IDX_PERIOD, 8'h05, RESP_OKAY);
    wr(IDX_COUNTER, 8'h00, RESP_OKAY);
    wr(IDX_TMR_CTRL, 8'h09, RESP_OKAY);
    cyc(30);
    wr(IDX_TMR_CTRL, 8'h00, RESP_OKAY);
    rd(IDX_COUNTER, d, RESP_OKAY);
    chk({31'h0, d[7:0] <= 8'h05}, 32'h1, "ctc bounded");
    rchk(IDX_IRQ_FLAG, 8'h00, "ctc no ovf");
    // PWM mode: compare C sets overflow
    wr(IDX_TMR_CTRL, 8'h05, RESP_OKAY);
    cyc(20);
    wr(IDX_TMR_CTRL, 8'h00, RESP_OKAY);
    rchk(IDX_IRQ_FLAG, 8'h04, "pwm ovf");
    wr(IDX_IRQ_FLAG, 8'h04, RESP_OKAY);
    // Fast clock control sequence
    wr(IDX_PLL_CTRL, 8'h7c, RESP_OKAY);
    rchk(IDX_PLL_CTRL, 8'h00, "src refused");
    wr(IDX_PLL_CTRL, 8'h03, RESP_OKAY);
    t0 = cyc_cnt;
    cyc(2);
    chk({31'h0, pll_run}, 32'h1, "pll running");
    d = '0;
    while (d[0] !== 1'b1) rd(IDX_PLL_CTRL, d, RESP_OKAY);
    chk({31'h0, (cyc_cnt - t0) >= LOCK_CYC}, 32'h1, "lock time");
    wr(IDX_PLL_CTRL, 8'h06, RESP_OKAY);
    rchk(IDX_PLL_CTRL, 8'h07, "pll status");
    chk({31'h0, fast_act}, 32'h1, "fast source");
    wr(IDX_COUNTER, 8'h00, RESP_OKAY);
    wr(IDX_TMR_CTRL, 8'h01, RESP_OKAY);
    ticks(10);
    wr(IDX_TMR_CTRL, 8'h00, RESP_OKAY);
    rchk(IDX_COUNTER, 8'h0a, "fast count");
    wr(IDX_PLL_CTRL, 8'h86, RESP_OKAY);
    wr(IDX_COUNTER, 8'h00, RESP_OKAY);
    wr(IDX_TMR_CTRL, 8'h01, RESP_OKAY);
    ticks(10);
    wr(IDX_TMR_CTRL, 8'h00, RESP_OKAY);
    rchk(IDX_COUNTER, 8'h05, "low speed count");
    wr(IDX_PLL_CTRL, 8'h00, RESP_OKAY);
    pll_sys <= 1'b1;
    cyc(2);
    rd(IDX_PLL_CTRL, d, RESP_OKAY);
    chk(d & 32'h2, 32'h2, "enable forced");
    print_verdict();
  end
endmodule // testbench
